// ---- hw/nfc_pkg.sv ----
// Constants and types for the NOR flash command sequencer.
`default_nettype none
package nfc_pkg;
  // ***********************************************************
  // Timing
  // ***********************************************************
  localparam int unsigned CLK_MHZ  = 250;
  localparam int unsigned T_AS_NS  = 10;
  localparam int unsigned T_WP_NS  = 50;
  localparam int unsigned T_WPH_NS = 30;
  localparam int unsigned T_ACC_NS = 80;
  localparam int unsigned T_RP_NS  = 500;
  localparam int unsigned SYNC_LAT = 4;
  localparam logic [7:0] AS_CYC  = 8'((T_AS_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] WP_CYC  = 8'((T_WP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] WPH_CYC = 8'((T_WPH_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] RD_CYC  =
    8'((T_ACC_NS * CLK_MHZ + 999) / 1000 + SYNC_LAT);
  localparam logic [7:0] RP_CYC  = 8'((T_RP_NS * CLK_MHZ + 999) / 1000);
  // ***********************************************************
  // Addresses and codes
  // ***********************************************************
  localparam logic [24:0] U1_BYTE = 25'h0000AAA;
  localparam logic [24:0] U2_BYTE = 25'h0000555;
  localparam logic [24:0] U1_WORD = 25'h0000555;
  localparam logic [24:0] U2_WORD = 25'h00002AA;
  localparam logic [15:0] D_UNL1  = 16'h00AA;
  localparam logic [15:0] D_UNL2  = 16'h0055;
  localparam logic [15:0] D_ERASE = 16'h0080;
  localparam logic [15:0] D_CHIP  = 16'h0010;
  localparam logic [15:0] D_GO30  = 16'h0030;
  localparam logic [15:0] D_RESET = 16'h00F0;
  localparam logic [15:0] D_CFI   = 16'h0098;
  localparam logic [15:0] D_SEL90 = 16'h0090;
  localparam logic [15:0] D_BYP   = 16'h0020;
  localparam logic [15:0] D_ZERO  = 16'h0000;
  localparam logic [15:0] D_SUSP  = 16'h00B0;
  localparam logic [15:0] D_BUF   = 16'h0025;
  localparam logic [15:0] D_CONF  = 16'h0029;
  localparam logic [15:0] D_BCK1  = 16'h00EB;
  localparam logic [15:0] D_BCK2  = 16'h0076;
  localparam int unsigned ABORT_BIT = 1;
  localparam logic [8:0] NMAX_BYTE = 9'h0FF;
  localparam logic [8:0] NMAX_WORD = 9'h1FF;
  // ***********************************************************
  // Types
  // ***********************************************************
  typedef enum logic [3:0] {
    OP_RESET = 4'h0, OP_RESET3 = 4'h1, OP_CFI = 4'h2, OP_ASEL = 4'h3,
    OP_BYP_ON = 4'h4, OP_BYP_OFF = 4'h5, OP_CHIP = 4'h6, OP_BLK = 4'h7,
    OP_MORE = 4'h8, OP_SUSP = 4'h9, OP_RESUME = 4'hA,
    OP_BLANK_SET = 4'hB, OP_BLANK_GO = 4'hC, OP_BUF = 4'hD,
    OP_READ = 4'hE, OP_HWRST = 4'hF
  } nfc_op_e;
  typedef enum logic [2:0] {
    M_READ = 3'h1, M_CFI = 3'h2, M_ASEL = 3'h4
  } nfc_mode_e;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01, ST_SETUP = 7'h02, ST_WE = 7'h04, ST_GAP = 7'h08,
    ST_LOAD = 7'h10, ST_RD = 7'h20, ST_HWRST = 7'h40
  } nfc_st_e;
  typedef struct packed {
    nfc_op_e     op;
    logic [24:0] blk;
    logic [8:0]  cnt;
  } nfc_req_s;
  typedef struct packed {
    logic [24:0] addr;
    logic [15:0] data;
    logic        last;
  } nfc_cyc_s;
  typedef struct packed {
    logic [24:0] addr;
    logic [15:0] dq;
    logic        dq_oe;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        rst_n;
    logic        byte_n;
  } nfc_pins_s;
  localparam nfc_pins_s PINS_RST = '{addr: 25'h0000000, dq: 16'h0000,
    dq_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b1,
    byte_n: 1'b0};
endpackage
`default_nettype wire

// ---- hw/nfc_host.sv ----
// Host-side command sequencer that drives a parallel NOR flash.
`default_nettype none
module nfc_host
  import nfc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        cfg_word,
  input  wire logic        cmd_valid,
  input  wire nfc_req_s    cmd_req,
  output var  logic        cmd_ready,
  output var  logic        cmd_done,
  output var  logic        cmd_err,
  output var  logic [15:0] rd_data,
  input  wire logic        wdat_valid,
  input  wire logic [15:0] wdat,
  input  wire logic [8:0]  wdat_loc,
  output var  logic        wdat_ready,
  input  wire logic [15:0] fl_dq_in,
  input  wire logic        fl_ready,
  output var  nfc_pins_s   pins,
  output var  nfc_mode_e   mode,
  output var  logic        bypass,
  output var  logic        suspended,
  output var  logic        abort_seen
);
  // ***********************************************************
  // Declarations
  // ***********************************************************
  nfc_st_e     st_r;
  nfc_req_s    cur_r;
  nfc_cyc_s    cyc;
  logic [2:0]  idx_r;
  logic [7:0]  tmr_r;
  logic [8:0]  cnt_r;
  logic        ld_r;
  logic        conf_r;
  logic [24:0] ld_addr_r;
  logic [15:0] ld_data_r;
  logic [15:0] dq_s1_r, dq_s2_r, dq_s3_r, dq_f_r;
  logic        ry_s1_r, ry_s2_r, ry_s3_r, ry_f_r;
  logic        more_ok_r, blank_ok_r, buf_pend_r;
  logic        take, fin, req_ok, tdone;
  logic [24:0] wa;
  logic [15:0] wd;
  logic [8:0]  nmax;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // Command cycle table: one address and data pair per step.
  function automatic nfc_cyc_s cyc_f(nfc_op_e op, logic [2:0] i,
    logic byp, logic wd16, logic [24:0] ba, logic [8:0] n);
    logic [24:0] u1;
    logic [24:0] u2;
    nfc_cyc_s    c;
    u1 = wd16 ? U1_WORD : U1_BYTE;
    u2 = wd16 ? U2_WORD : U2_BYTE;
    c = '{addr: 25'h0000000, data: D_ZERO, last: 1'b1};
    if (i == 3'h0) c = '{addr: u1, data: D_UNL1, last: 1'b0};
    if (i == 3'h1) c = '{addr: u2, data: D_UNL2, last: 1'b0};
    case (op)
      OP_RESET:    c = '{addr: 25'h0000000, data: D_RESET, last: 1'b1};
      // The abort form wants the unlock address on its third write too.
      OP_RESET3:   if (i == 3'h2) c = '{addr: u1, data: D_RESET, last: 1'b1};
      OP_CFI:      c = '{addr: u1, data: D_CFI, last: 1'b1};
      OP_ASEL:     if (i == 3'h2) c = '{addr: u1, data: D_SEL90, last: 1'b1};
      OP_BYP_ON:   if (i == 3'h2) c = '{addr: u1, data: D_BYP, last: 1'b1};
      OP_BYP_OFF:  c = '{addr: 25'h0000000,
                         data: (i == 3'h0) ? D_SEL90 : D_ZERO,
                         last: (i != 3'h0)};
      OP_CHIP, OP_BLK: begin
        if (byp) begin
          c = '{addr: 25'h0000000, data: D_ERASE, last: 1'b0};
          if (i != 3'h0) c = (op == OP_CHIP) ?
            '{addr: 25'h0000000, data: D_CHIP, last: 1'b1} :
            '{addr: ba, data: D_GO30, last: 1'b1};
        end else begin
          if (i == 3'h2) c = '{addr: u1, data: D_ERASE, last: 1'b0};
          if (i == 3'h3) c = '{addr: u1, data: D_UNL1, last: 1'b0};
          if (i == 3'h4) c = '{addr: u2, data: D_UNL2, last: 1'b0};
          if (i == 3'h5) c = (op == OP_CHIP) ?
            '{addr: u1, data: D_CHIP, last: 1'b1} :
            '{addr: ba, data: D_GO30, last: 1'b1};
        end
      end
      OP_MORE:     c = '{addr: ba, data: D_GO30, last: 1'b1};
      OP_SUSP:     c = '{addr: 25'h0000000, data: D_SUSP, last: 1'b1};
      OP_RESUME:   c = '{addr: 25'h0000000, data: D_GO30, last: 1'b1};
      OP_BLANK_SET: if (i > 3'h1) c = '{addr: ba,
        data: (i == 3'h2) ? D_BCK1 : (i == 3'h3) ? D_BCK2 : D_ZERO,
        last: (i == 3'h5)};
      OP_BLANK_GO: c = '{addr: ba, data: D_CONF, last: 1'b1};
      OP_BUF: if (byp || i > 3'h1) c = '{addr: ba,
        data: ((byp ? i : i - 3'h2) == 3'h0) ? D_BUF : {7'h00, n},
        last: ((byp ? i : i - 3'h2) != 3'h0)};
      default: c = '{addr: 25'h0000000, data: D_ZERO, last: 1'b1};
    endcase
    return c;
  endfunction

  // ***********************************************************
  // Pin synchronisers
  // ***********************************************************
  // A bit changes only once the second and third stages agree.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dq_s1_r <= 16'h0000;
      dq_s2_r <= 16'h0000;
      dq_s3_r <= 16'h0000;
      dq_f_r  <= 16'h0000;
      ry_s1_r <= 1'b1;
      ry_s2_r <= 1'b1;
      ry_s3_r <= 1'b1;
      ry_f_r  <= 1'b1;
    end else begin
      dq_s1_r <= fl_dq_in;
      dq_s2_r <= dq_s1_r;
      dq_s3_r <= dq_s2_r;
      dq_f_r  <= (dq_s2_r & ~(dq_s2_r ^ dq_s3_r))
               | (dq_f_r & (dq_s2_r ^ dq_s3_r));
      ry_s1_r <= fl_ready;
      ry_s2_r <= ry_s1_r;
      ry_s3_r <= ry_s2_r;
      if (ry_s2_r == ry_s3_r) ry_f_r <= ry_s2_r;
    end
  end

  // ***********************************************************
  // Request check
  // ***********************************************************
  assign nmax = cfg_word ? NMAX_WORD : NMAX_BYTE;
  assign take = (st_r == ST_IDLE) && cmd_valid && cmd_ready;
  assign tdone = (tmr_r == 8'h00);
  assign cyc = cyc_f(cur_r.op, idx_r, bypass, cfg_word, cur_r.blk,
                     cur_r.cnt);
  assign wa = conf_r ? cur_r.blk : ld_r ? ld_addr_r : cyc.addr;
  assign wd = conf_r ? D_CONF : ld_r ? ld_data_r : cyc.data;
  assign fin = (st_r == ST_GAP && tdone &&
                (conf_r || (!ld_r && cyc.last && cur_r.op != OP_BUF)))
             || ((st_r == ST_RD || st_r == ST_HWRST) && tdone);

  always_comb begin
    req_ok = 1'b1;
    case (cmd_req.op)
      OP_CFI, OP_ASEL: req_ok = (mode != M_CFI);
      OP_BYP_ON:    req_ok = !bypass;
      OP_BYP_OFF:   req_ok = bypass;
      OP_MORE:      req_ok = more_ok_r;
      OP_BLANK_GO:  req_ok = blank_ok_r;
      OP_BUF:       req_ok = (cmd_req.cnt <= nmax) && (mode == M_READ);
      OP_CHIP, OP_BLK, OP_BLANK_SET: req_ok = (mode == M_READ);
      default:      req_ok = 1'b1;
    endcase
    // Busy flash: only suspend, status reads, hardware reset and extra erase blocks pass.
    // Extra erase blocks are queued while the first erase is pending.
    if (!ry_f_r && !(cmd_req.op inside {OP_SUSP, OP_READ, OP_HWRST,
        OP_MORE})) req_ok = 1'b0;
  end

  // ***********************************************************
  // Bus cycle sequencer
  // ***********************************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r      <= ST_IDLE;
      cur_r     <= '{op: OP_RESET, blk: 25'h0000000, cnt: 9'h000};
      idx_r     <= 3'h0;
      tmr_r     <= 8'h00;
      cnt_r     <= 9'h000;
      ld_r      <= 1'b0;
      conf_r    <= 1'b0;
      ld_addr_r <= 25'h0000000;
      ld_data_r <= 16'h0000;
      pins      <= PINS_RST;
      cmd_ready <= 1'b1;
      cmd_done  <= 1'b0;
      cmd_err   <= 1'b0;
      rd_data   <= 16'h0000;
      wdat_ready <= 1'b0;
    end else begin
      cmd_done    <= 1'b0;
      cmd_err     <= 1'b0;
      pins.byte_n <= cfg_word;
      if (tmr_r != 8'h00) tmr_r <= tmr_r - 8'h01;
      unique case (st_r)
        ST_IDLE: if (take) begin
          if (!req_ok) begin
            cmd_err <= 1'b1;
          end else begin
            cmd_ready <= 1'b0;
            cur_r <= cmd_req;
            // A pending abort needs the full three-cycle reset.
            if (cmd_req.op == OP_RESET && abort_seen)
              cur_r.op <= OP_RESET3;
            idx_r <= 3'h0;
            ld_r <= 1'b0;
            conf_r <= 1'b0;
            if (cmd_req.op == OP_READ) begin
              st_r <= ST_RD;
              pins.addr <= cmd_req.blk;
              pins.ce_n <= 1'b0;
              pins.oe_n <= 1'b0;
              tmr_r <= RD_CYC - 8'h01;
            end else if (cmd_req.op == OP_HWRST) begin
              st_r <= ST_HWRST;
              pins.rst_n <= 1'b0;
              tmr_r <= RP_CYC - 8'h01;
            end else begin
              st_r <= ST_SETUP;
              tmr_r <= AS_CYC - 8'h01;
            end
          end
        end
        ST_SETUP: begin
          pins.addr  <= wa;
          pins.dq    <= wd;
          pins.dq_oe <= 1'b1;
          pins.ce_n  <= 1'b0;
          if (tdone) begin
            st_r <= ST_WE;
            pins.we_n <= 1'b0;
            tmr_r <= WP_CYC - 8'h01;
          end
        end
        ST_WE: if (tdone) begin
          st_r <= ST_GAP;
          pins.we_n <= 1'b1;
          tmr_r <= WPH_CYC - 8'h01;
        end
        ST_GAP: if (tdone) begin
          pins.ce_n  <= 1'b1;
          pins.dq_oe <= 1'b0;
          tmr_r <= AS_CYC - 8'h01;
          if (fin) begin
            st_r <= ST_IDLE;
            cmd_ready <= 1'b1;
            cmd_done <= 1'b1;
          end else if (ld_r && cnt_r == 9'h000) begin
            ld_r <= 1'b0;
            conf_r <= 1'b1;
            st_r <= ST_SETUP;
          end else if (ld_r || cyc.last) begin
            // Count N was written, so N+1 entries follow.
            cnt_r <= ld_r ? cnt_r - 9'h001 : cur_r.cnt;
            ld_r <= 1'b1;
            wdat_ready <= 1'b1;
            st_r <= ST_LOAD;
          end else begin
            idx_r <= idx_r + 3'h1;
            st_r <= ST_SETUP;
          end
        end
        ST_LOAD: if (wdat_valid && wdat_ready) begin
          wdat_ready <= 1'b0;
          ld_data_r <= wdat;
          // Only the entry-select bits come from the user side.
          ld_addr_r <= cfg_word ? {cur_r.blk[24:9], wdat_loc} :
                       {cur_r.blk[24:8], wdat_loc[7:0]};
          st_r <= ST_SETUP;
          tmr_r <= AS_CYC - 8'h01;
        end
        ST_RD: if (tdone) begin
          rd_data <= dq_f_r;
          pins.ce_n <= 1'b1;
          pins.oe_n <= 1'b1;
          st_r <= ST_IDLE;
          cmd_ready <= 1'b1;
          cmd_done <= 1'b1;
        end
        ST_HWRST: if (tdone) begin
          pins.rst_n <= 1'b1;
          st_r <= ST_IDLE;
          cmd_ready <= 1'b1;
          cmd_done <= 1'b1;
        end
      endcase
    end
  end

  // ***********************************************************
  // Mode tracking
  // ***********************************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode <= M_READ;
      bypass <= 1'b0;
      suspended <= 1'b0;
    end else if (fin) begin
      case (cur_r.op)
        OP_HWRST: begin
          mode <= M_READ;
          bypass <= 1'b0;
          suspended <= 1'b0;
        end
        // Suspend survives a reset, so query or auto select falls back.
        OP_RESET, OP_RESET3: mode <= M_READ;
        OP_CFI:     mode <= M_CFI;
        OP_ASEL:    mode <= M_ASEL;
        OP_BYP_ON:  bypass <= 1'b1;
        OP_BYP_OFF: bypass <= 1'b0;
        OP_SUSP:    suspended <= 1'b1;
        OP_RESUME: begin
          suspended <= 1'b0;
          mode <= M_READ;
        end
        default: ;
      endcase
    end
  end

  // ***********************************************************
  // Sequence flags
  // ***********************************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      more_ok_r <= 1'b0;
      blank_ok_r <= 1'b0;
      buf_pend_r <= 1'b0;
      abort_seen <= 1'b0;
    end else if (fin) begin
      more_ok_r <= (cur_r.op == OP_BLK) || (cur_r.op == OP_MORE);
      blank_ok_r <= (cur_r.op == OP_BLANK_SET);
      buf_pend_r <= (cur_r.op == OP_BUF) ||
                    (buf_pend_r && cur_r.op == OP_READ);
      if (cur_r.op == OP_READ && buf_pend_r && dq_f_r[ABORT_BIT])
        abort_seen <= 1'b1;
      else if (cur_r.op == OP_RESET3 || cur_r.op == OP_HWRST)
        abort_seen <= 1'b0;
    end
  end

  // ***********************************************************
  // Checks
  // ***********************************************************
  property p_chip;
    fin && cur_r.op == OP_CHIP |-> idx_r == (bypass ? 3'h1 : 3'h5)
      && pins.dq == D_CHIP;
  endproperty
  a_chip: assert property (p_chip) else $error("chip erase length");
  property p_blk;
    fin && cur_r.op == OP_BLK |-> pins.addr == cur_r.blk
      && pins.dq == D_GO30 && idx_r == (bypass ? 3'h1 : 3'h5);
  endproperty
  a_blk: assert property (p_blk) else $error("block erase form");
  property p_blank;
    fin && cur_r.op == OP_BLANK_SET |-> idx_r == 3'h5
      && pins.addr == cur_r.blk;
  endproperty
  a_blank: assert property (p_blank) else $error("blank setup");
  property p_abort;
    take && req_ok && abort_seen && cmd_req.op == OP_RESET
      |=> cur_r.op == OP_RESET3;
  endproperty
  a_abort: assert property (p_abort) else $error("short reset");
  property p_busy;
    take && !ry_f_r && !(cmd_req.op inside {OP_SUSP, OP_READ, OP_HWRST,
      OP_MORE}) |=> cmd_err && cmd_ready && st_r == ST_IDLE;
  endproperty
  a_busy: assert property (p_busy) else $error("busy command");
  property p_byp;
    fin && cur_r.op inside {OP_RESET, OP_RESET3} |=> $stable(bypass);
  endproperty
  a_byp: assert property (p_byp) else $error("reset left bypass");
  property p_susp;
    fin && cur_r.op == OP_RESET && suspended |=> suspended
      && mode == M_READ;
  endproperty
  a_susp: assert property (p_susp) else $error("suspend lost");
  property p_hw;
    fin && cur_r.op == OP_HWRST |=> mode == M_READ && !bypass
      && pins.rst_n;
  endproperty
  a_hw: assert property (p_hw) else $error("hw reset mode");
  property p_asel;
    fin && cur_r.op == OP_ASEL |-> idx_r == 3'h2 && pins.dq == D_SEL90
      ##1 mode == M_ASEL;
  endproperty
  a_asel: assert property (p_asel) else $error("auto select");
  property p_conf;
    st_r == ST_WE && conf_r |-> pins.addr == cur_r.blk
      && pins.dq == D_CONF;
  endproperty
  a_conf: assert property (p_conf) else $error("confirm address");
  property p_upper;
    st_r == ST_WE && ld_r |-> pins.addr[24:9] == cur_r.blk[24:9];
  endproperty
  a_upper: assert property (p_upper) else $error("load address");
  property p_we;
    $fell(pins.we_n) |-> (!pins.we_n)[*8];
  endproperty
  a_we: assert property (p_we) else $error("write pulse short");
endmodule
`default_nettype wire

// ---- verif/nfc_flash_model.sv ----
// Behavioural parallel NOR flash that answers the host sequencer.
`default_nettype none
module nfc_flash_model
  import nfc_pkg::*;
#(
  parameter int          BUSY_NS = 2000,
  parameter logic [15:0] MFR_ID  = 16'h00C3 // Arbitrary value.
)(
  input  wire nfc_pins_s   pins,
  input  wire logic        abort_on,
  output var  logic [15:0] fl_dq_in,
  output var  logic        fl_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // ***********************************************************
  // State
  // ***********************************************************
  nfc_mode_e   md;
  logic        byp, susp, aborted;
  logic [7:0]  d, prev;
  logic [15:0] last;
  int          unl, left, tok;
  task automatic hw_init();
    md = M_READ;
    byp = 1'b0;
    susp = 1'b0;
    aborted = 1'b0;
    fl_ready = 1'b1;
    unl = 0;
    left = -1;
    last = 16'h0000;
  endtask
  // Busy is a timed pulse; a suspend bumps the token so it is dropped.
  task automatic go_busy();
    int t;
    tok++;
    t = tok;
    fl_ready = 1'b0;
    fork
      begin
        #(BUSY_NS);
        if (t == tok) fl_ready = 1'b1;
      end
    join_none
  endtask
  initial hw_init();
  always @(negedge pins.rst_n) hw_init();
  // ***********************************************************
  // Write decode
  // ***********************************************************
  always @(posedge pins.we_n) if (pins.ce_n === 1'b0) begin
    d = pins.dq[7:0];
    if (left == -2) left = int'(pins.dq) + 1;
    else if (left > 0) left--;
    else if (left == 0) begin
      left = -1;
      aborted = abort_on;
      go_busy();
    end else if (d == 8'hAA || d == 8'h55) unl++;
    else begin
      case (d)
        8'hF0: if (fl_ready && (!aborted || unl >= 2)) begin
          md = M_READ;
          aborted = 1'b0;
        end
        8'h98: if (md != M_CFI) md = M_CFI;
        8'h90: if (unl >= 2 && fl_ready) md = M_ASEL;
        8'h00: if (byp && prev == 8'h90) byp = 1'b0;
        8'h20: if (unl >= 2) byp = 1'b1;
        8'h25: left = -2;
        8'hB0: if (!fl_ready) begin
          susp = 1'b1;
          tok++;
          fl_ready = 1'b1;
        end
        8'h10, 8'h29: go_busy();
        8'h30: begin
          susp = 1'b0;
          go_busy();
        end
        default: ;
      endcase
      unl = 0;
    end
    prev = d;
  end
  // ***********************************************************
  // Read data; a released bus shows the inverse of its last value
  // ***********************************************************
  always @(pins or md or aborted) begin
    if (!pins.ce_n && !pins.oe_n) begin
      fl_dq_in = aborted ? 16'h0002 : md == M_CFI ? 16'h0051 :
        md == M_ASEL ? MFR_ID : {pins.addr[7:0], ~pins.addr[7:0]};
      last = fl_dq_in;
    end else fl_dq_in = ~last;
  end
endmodule
`default_nettype wire

// ---- verif/nfc_host_tb.sv ----
// Self-checking bench for the NOR flash host sequencer.
`default_nettype none
module nfc_host_tb
  import nfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ***********************************************************
  // Signals
  // ***********************************************************
  localparam logic [24:0] BA = 25'h0120000;
  logic        ref_clk, reset_n, cfg_word, cmd_valid, cmd_ready;
  logic        cmd_done, cmd_err, wdat_valid, wdat_ready, fl_ready;
  logic        bypass, suspended, abort_seen, abort_on;
  logic [15:0] rd_data, wdat, fl_dq_in;
  logic [8:0]  wdat_loc;
  logic [24:0] u1, u2;
  nfc_req_s    cmd_req;
  nfc_pins_s   pins;
  nfc_mode_e   mode;
  logic [15:0] bd[$];
  logic [40:0] exp_q[$];
  int          err_total, n_compared, seed, bi, nb;
  assign u1 = cfg_word ? U1_WORD : U1_BYTE;
  assign u2 = cfg_word ? U2_WORD : U2_BYTE;
  nfc_host nfc_host_i (.ref_clk, .reset_n, .cfg_word, .cmd_valid,
    .cmd_req, .cmd_ready, .cmd_done, .cmd_err, .rd_data, .wdat_valid,
    .wdat, .wdat_loc, .wdat_ready, .fl_dq_in, .fl_ready, .pins, .mode,
    .bypass, .suspended, .abort_seen);
  nfc_flash_model nfc_flash_model_i (.pins, .abort_on, .fl_dq_in,
    .fl_ready);
  // ***********************************************************
  // Tasks
  // ***********************************************************
  task automatic check(string what, logic [40:0] seen, logic [40:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("errors %0d compared %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(logic [24:0] a, logic [15:0] d);
    exp_q.push_back({a, d});
  endtask
  task automatic unl(logic [24:0] a, logic [15:0] d);
    wr(u1, 16'h00AA);
    wr(u2, 16'h0055);
    wr(a, d);
  endtask
  task automatic run(nfc_op_e op, logic [24:0] blk, logic [8:0] cnt,
                     logic err);
    int n;
    cmd_valid <= 1'b1;
    cmd_req <= '{op: op, blk: blk, cnt: cnt};
    do @(posedge ref_clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (cmd_done !== 1'b1 && cmd_err !== 1'b1 && n < 4000);
    check("done_in_time", 41'(n < 4000), 41'(1));
    check("refused", cmd_err, err);
    check("pending_writes", 41'(exp_q.size()), '0);
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (fl_ready !== 1'b1 && n < 2000);
    check("ready_in_time", 41'(n < 2000), 41'(1));
    repeat (6) @(posedge ref_clk);
  endtask
  // ***********************************************************
  // Processes
  // ***********************************************************
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Every flash write is matched against the oldest expected cycle.
  always @(posedge pins.we_n) if (pins.ce_n === 1'b0) begin
    if (exp_q.size() == 0) check("extra_write", {pins.addr, pins.dq}, '1);
    else check("write", {pins.addr, pins.dq}, exp_q.pop_front());
  end
  always @(posedge ref_clk) if (wdat_valid && wdat_ready === 1'b1) begin
    bi = bi + 1;
    wdat_valid <= (bi < nb);
    wdat <= bd[bi % nb];
    wdat_loc <= 9'(bi);
  end
  initial begin
    #200000;
    err_total++;
    summarize();
  end
  initial begin
    seed = 65891;
    {reset_n, cfg_word, cmd_valid, wdat_valid, abort_on} = '0;
    {cmd_req, wdat, wdat_loc, bi, nb, err_total, n_compared} = '0;
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    check("mode", {mode, cmd_ready}, {M_READ, 1'b1});
    unl(U1_BYTE, 16'h0080);
    unl(U1_BYTE, 16'h0010);
    run(OP_CHIP, '0, '0, 1'b0);
    run(OP_RESET, '0, '0, 1'b1);
    run(OP_ASEL, '0, '0, 1'b1);
    wr('0, 16'h00B0);
    run(OP_SUSP, '0, '0, 1'b0);
    repeat (6) @(posedge ref_clk);
    unl(U1_BYTE, 16'h0090);
    run(OP_ASEL, '0, '0, 1'b0);
    check("mode", mode, M_ASEL);
    wr('0, 16'h00F0);
    run(OP_RESET, '0, '0, 1'b0);
    check("suspend", {mode, suspended}, {M_READ, 1'b1});
    wr('0, 16'h0030);
    run(OP_RESUME, '0, '0, 1'b0);
    wait_rdy();
    run(OP_BUF, BA, 9'h100, 1'b1);
    wr(U1_BYTE, 16'h0098);
    run(OP_CFI, '0, '0, 1'b0);
    check("mode", mode, M_CFI);
    run(OP_CFI, '0, '0, 1'b1);
    run(OP_READ, BA, '0, 1'b0);
    check("cfi_data", rd_data, 16'h0051);
    unl(U1_BYTE, 16'h0020);
    run(OP_BYP_ON, '0, '0, 1'b0);
    wr('0, 16'h00F0);
    run(OP_RESET, '0, '0, 1'b0);
    check("bypass", {mode, bypass}, {M_READ, 1'b1});
    wr('0, 16'h0080);
    wr(BA, 16'h0030);
    run(OP_BLK, BA, '0, 1'b0);
    wait_rdy();
    wr('0, 16'h0080);
    wr('0, 16'h0010);
    run(OP_CHIP, '0, '0, 1'b0);
    wait_rdy();
    wr('0, 16'h0090);
    wr('0, 16'h0000);
    run(OP_BYP_OFF, '0, '0, 1'b0);
    check("bypass", bypass, 1'b0);
    reset_n <= 1'b0;
    cfg_word <= 1'b1;
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    unl(U1_WORD, 16'h0080);
    unl(BA, 16'h0030);
    run(OP_BLK, BA, '0, 1'b0);
    check("byte_n", pins.byte_n, 1'b1);
    wr(25'h0140000, 16'h0030);
    run(OP_MORE, 25'h0140000, '0, 1'b0);
    wait_rdy();
    unl(U1_WORD, 16'h0090);
    run(OP_ASEL, '0, '0, 1'b0);
    run(OP_READ, '0, '0, 1'b0);
    check("ident", rd_data, 16'h00C3);
    wr(U1_WORD, 16'h0098);
    run(OP_CFI, '0, '0, 1'b0);
    check("mode", mode, M_CFI);
    wr('0, 16'h00F0);
    run(OP_RESET, '0, '0, 1'b0);
    run(OP_MORE, BA, '0, 1'b1);
    unl(BA, 16'h00EB);
    wr(BA, 16'h0076);
    wr(BA, 16'h0000);
    wr(BA, 16'h0000);
    run(OP_BLANK_SET, BA, '0, 1'b0);
    wr(BA, 16'h0029);
    run(OP_BLANK_GO, BA, '0, 1'b0);
    wait_rdy();
    nb = 1 + ($random(seed) & 15);
    for (int i = 0; i < nb; i++) bd.push_back(16'($random(seed)));
    unl(BA, 16'h0025);
    wr(BA, 16'(nb - 1));
    for (int i = 0; i < nb; i++) wr({BA[24:9], 9'(i)}, bd[i]);
    wr(BA, 16'h0029);
    abort_on <= 1'b1;
    wdat <= bd[0];
    wdat_valid <= 1'b1;
    run(OP_BUF, BA, 9'(nb - 1), 1'b0);
    wait_rdy();
    run(OP_READ, BA, '0, 1'b0);
    check("abort", abort_seen, 1'b1);
    unl(U1_WORD, 16'h00F0);
    run(OP_RESET, '0, '0, 1'b0);
    check("abort", abort_seen, 1'b0);
    run(OP_HWRST, '0, '0, 1'b0);
    check("hw_reset", {mode, bypass, pins.rst_n}, {M_READ, 2'b01});
    summarize();
  end
endmodule
`default_nettype wire
